// ---- src/rcsp_defs.svh ----
// Macro constants for the radio control serial port.
`ifndef RCSP_DEFS_SVH
`define RCSP_DEFS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define RCSP_FRAME_BITS 5'd16
`define RCSP_CMD_LAST 5'd7
`define RCSP_DATA_FIRST 5'd8
`define RCSP_CNT_RST 5'h00

// ----------------------------------------------------------------
// Command byte fields (bit 7 is the start bit, always one)
// ----------------------------------------------------------------
`define RCSP_ADDR_HI 6
`define RCSP_ADDR_LO 4
`define RCSP_RECEIVE_ENABLE_BIT_POS 3
`define RCSP_TRANSMIT_ENABLE_BIT_POS 2
`define RCSP_SD_POS 1
`define RCSP_LD_POS 0

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define RCSP_ADR_XTAL 3'h0
`define RCSP_ADR_PSNS 3'h1
`define RCSP_ADR_GAIN 3'h2
`define RCSP_ADR_BIAS 3'h3
`define RCSP_ADR_ADC 3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RCSP_BYTE_RST 8'h00
`define RCSP_MODE_RST 2'h0

// ----------------------------------------------------------------
// Diversity sequence timing in clocks
// ----------------------------------------------------------------
`define RCSP_DIV_WAIT 4'd4
`define RCSP_DIV_ACQ 4'd8
`define RCSP_DIV_GAP 4'd4
`define RCSP_DIV_CMP 4'd8
`define RCSP_DIV_ONE 4'd1

`endif

// ---- src/rcsp_pkg.sv ----
// Package with the types shared by the serial port files.
package rcsp_pkg;

   // Power modes in {receive_enable_bit, transmit_enable_bit} order.
   typedef enum logic [1:0] {
      RCSP_TOTAL_SHUTDOWN = 2'h0,
      RCSP_TRANSMIT = 2'h1,
      RCSP_RECEIVE = 2'h2,
      RCSP_STANDBY = 2'h3
   } rcsp_mode_t;

   // Decoded command byte.
   typedef struct packed {
      logic [2:0] addr;
      logic receive_enable_bit;
      logic transmit_enable_bit;
      logic bias_shutdown_bit;
      logic load_strobe_bit;
   } rcsp_cmd_t;

   // One completed frame passed from the serial domain.
   typedef struct packed {
      rcsp_cmd_t cmd;
      logic [7:0] data;
   } rcsp_frame_t;

   // Active output settings.
   typedef struct packed {
      logic [5:0] crystal_tune_converter;
      logic [6:0] power_sense_converter;
      logic [6:0] gain_converter;
      logic [5:0] gate_bias_converter;
      logic forward_sense;
      logic direct_adc_select;
      logic [1:0] power_class;
      logic bias_shutdown_output;
      rcsp_mode_t mode;
   } rcsp_active_t;

endpackage

// ---- src/rcsp_diversity.sv ----
// Antenna diversity sequencer with the best antenna latch.
`timescale 1ns/10ps
`include "rcsp_defs.svh"

module rcsp_diversity (
   input wire logic clock, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic window_sync, // Synchronised diversity window.
   input wire logic compare_in, // Synchronised comparator result.
   output logic diversity_measure_control, // Measurement control.
   output logic best_antenna_output // Latched best antenna.
);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum {
      RCSP_DV_IDLE,
      RCSP_DV_WAIT,
      RCSP_DV_ACQ,
      RCSP_DV_GAP,
      RCSP_DV_CMP,
      RCSP_DV_END
   } rcsp_dv_state_t;

   rcsp_dv_state_t state_q; // Sequence position.
   logic [3:0] cnt_q; // Clocks spent in the current phase.
   logic win_q; // Window seen last clock, for edge finding.

   // The window is sampled once per clock; its falling edge ends any phase.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_q <= RCSP_DV_IDLE;
         cnt_q <= 4'h0;
         win_q <= 1'b0;
      end else begin
         win_q <= window_sync;
         cnt_q <= cnt_q + 4'h1;
         if (win_q && !window_sync && state_q != RCSP_DV_IDLE) begin
            state_q <= RCSP_DV_END;
            cnt_q <= 4'h0;
         end else begin
            case (state_q)
               RCSP_DV_IDLE: begin
                  cnt_q <= 4'h0;
                  if (window_sync && !win_q) begin
                     state_q <= RCSP_DV_WAIT;
                  end
               end
               RCSP_DV_WAIT: begin
                  if (cnt_q == `RCSP_DIV_WAIT - 4'h1) begin
                     state_q <= RCSP_DV_ACQ;
                     cnt_q <= 4'h0;
                  end
               end
               RCSP_DV_ACQ: begin
                  if (cnt_q == `RCSP_DIV_ACQ - 4'h1) begin
                     state_q <= RCSP_DV_GAP;
                     cnt_q <= 4'h0;
                  end
               end
               RCSP_DV_GAP: begin
                  if (cnt_q == `RCSP_DIV_GAP - 4'h1) begin
                     state_q <= RCSP_DV_CMP;
                     cnt_q <= 4'h0;
                  end
               end
               RCSP_DV_CMP: begin
                  // Holds high past eight clocks until the window falls.
                  if (cnt_q == `RCSP_DIV_CMP) begin
                     cnt_q <= `RCSP_DIV_CMP;
                  end
               end
               RCSP_DV_END: begin
                  if (cnt_q == `RCSP_DIV_ONE - 4'h1) begin
                     state_q <= RCSP_DV_IDLE;
                  end
               end
               default: state_q <= RCSP_DV_IDLE;
            endcase
         end
      end
   end

   // Control is high in acquire and compare, and one clock after the fall.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         diversity_measure_control <= 1'b0;
      end else begin
         diversity_measure_control <=
            (state_q == RCSP_DV_ACQ) || (state_q == RCSP_DV_CMP) ||
            (state_q == RCSP_DV_END);
      end
   end

   // Comparator is clocked in on the falling window; reset gives low.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         best_antenna_output <= 1'b0;
      end else if (win_q && !window_sync) begin
         best_antenna_output <= compare_in;
      end
   end

endmodule

// ---- src/rcsp_top.sv ----
// Serial control port and control logic of the radio support block.
//
// Functional notes
// - Start bit opens 16-bit command-data frame.
// - Start clears registers, counts, latches seven bits.
// - Sample on falling, shift out on rising.
// - Serial port works in every power mode.
// - Command decodes address, modes, shutdown, load.
// - Shutdown bit zero drives bias output low.
// - Write fills only addressed input buffer.
// - Load zero leaves all outputs unchanged.
// - Load one copies all buffers after frame.
// - Read shifts result out MSB first.
// - Read with load also transfers buffers.
// - Mode bits select shutdown, transmit, receive, standby.
// - Power-up gives total shutdown, port ready.
// - Sense inputs grounded unless gain stage selects.
// - Reset clears best antenna output low.
// - Wait four clocks, then raise measure control.
// - Acquire eight, gap four, compare until window falls.
// - Window fall latches comparator into result.
// - Control falls one clock after window fall.
// - Address codes select converters or ADC read.
// - Data bit seven selects sense, input; bits seven and six give class.
// - Converter outputs reset to zero.
`timescale 1ns/10ps
`include "rcsp_defs.svh"

module rcsp_top (
   input wire logic clock, // System clock, 200 MHz.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic serial_clock, // Serial clock from the host.
   input wire logic frame_select_n, // Frame select, active low.
   input wire logic serial_data_in, // Serial data from the host.
   output logic serial_data_out, // Serial data to the host.
   input wire logic [7:0] adc_result, // Latest ADC conversion result.
   input wire logic diversity_window_input, // Diversity window pin.
   input wire logic peak_window_input, // Power sense window pin.
   input wire logic compare_result, // Diversity comparator output.
   output logic diversity_measure_control, // Diversity measure control.
   output logic best_antenna_output, // Best antenna result.
   output logic bias_shutdown_output, // Bias generator shutdown.
   output logic [5:0] crystal_tune_converter, // Crystal tune code.
   output logic [6:0] power_sense_converter, // Power sense code.
   output logic [6:0] gain_converter, // Gain code.
   output logic [5:0] gate_bias_converter, // Gate bias code.
   output logic gate_bias_enable, // Gate bias converter enable.
   output logic [1:0] power_class, // Active power class.
   output logic forward_sense, // One selects forward sensing.
   output logic direct_adc_select, // One selects the direct input.
   output logic [1:0] power_mode, // Receive and transmit enables.
   output logic [3:0] converter_enable, // Xtal, sense, gain, bias.
   output logic [2:0] sense_pulldown // Reverse, fwd one, fwd two.
);

   // ----------------------------------------------------------------
   // Decode helper
   // ----------------------------------------------------------------
   // Splits a raw command byte into its fields.
   function automatic rcsp_pkg::rcsp_cmd_t rcsp_decode(input logic [7:0] b);
      rcsp_pkg::rcsp_cmd_t c;
      c.addr = b[`RCSP_ADDR_HI:`RCSP_ADDR_LO];
      c.receive_enable_bit = b[`RCSP_RECEIVE_ENABLE_BIT_POS];
      c.transmit_enable_bit = b[`RCSP_TRANSMIT_ENABLE_BIT_POS];
      c.bias_shutdown_bit = b[`RCSP_SD_POS];
      c.load_strobe_bit = b[`RCSP_LD_POS];
      return c;
   endfunction

   // ----------------------------------------------------------------
   // Serial clock domain
   // ----------------------------------------------------------------
   // This domain has no power gating, so commands work in every mode.
   logic [4:0] bit_cnt_q; // Bits of the frame received, zero when idle.
   logic [7:0] cmd_q; // Command shift register.
   logic [7:0] data_q; // Data shift register.
   logic [7:0] out_q; // Read shift register.
   logic frame_done_q; // High from the last data bit until select rises.
   rcsp_pkg::rcsp_frame_t frame_q; // Frame held stable for the crossing.

   // Select high holds the counter at zero so a short frame is dropped.
   always_ff @(negedge serial_clock or posedge frame_select_n) begin
      if (frame_select_n) begin
         bit_cnt_q <= `RCSP_CNT_RST;
         frame_done_q <= 1'b0;
         cmd_q <= `RCSP_BYTE_RST;
         data_q <= `RCSP_BYTE_RST;
      end else if (bit_cnt_q == `RCSP_CNT_RST) begin
         if (serial_data_in) begin
            bit_cnt_q <= 5'd1;
            cmd_q <= 8'h01;
            data_q <= `RCSP_BYTE_RST;
         end
      end else if (bit_cnt_q != `RCSP_FRAME_BITS) begin
         bit_cnt_q <= bit_cnt_q + 5'd1;
         frame_done_q <= (bit_cnt_q == `RCSP_FRAME_BITS - 5'd1);
         if (bit_cnt_q <= `RCSP_CMD_LAST) begin
            cmd_q <= {cmd_q[6:0], serial_data_in};
         end else begin
            data_q <= {data_q[6:0], serial_data_in};
         end
      end
   end

   // Hands a finished frame over on the last data bit.
   always_ff @(negedge serial_clock) begin
      if (!frame_select_n && bit_cnt_q == `RCSP_FRAME_BITS - 5'd1) begin
         frame_q <= {rcsp_decode(cmd_q), data_q[6:0], serial_data_in};
      end
   end

   // Read data leaves on rising edges, high bit first, over the last eight.
   always_ff @(posedge serial_clock or posedge frame_select_n) begin
      if (frame_select_n) begin
         out_q <= `RCSP_BYTE_RST;
         serial_data_out <= 1'b0;
      end else if (bit_cnt_q == `RCSP_DATA_FIRST &&
                   cmd_q[`RCSP_ADDR_HI:`RCSP_ADDR_LO] == `RCSP_ADR_ADC) begin
         serial_data_out <= adc_result[7];
         out_q <= {adc_result[6:0], 1'b0};
      end else if (bit_cnt_q > `RCSP_DATA_FIRST) begin
         serial_data_out <= out_q[7];
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // Crossing into the system clock
   // ----------------------------------------------------------------
   logic [2:0] tgl_sync_q; // Done flag synchroniser and edge stage.
   logic [1:0] win_sync_q; // Diversity window synchroniser.
   logic [1:0] pk_sync_q; // Peak window synchroniser.
   logic [1:0] cmp_sync_q; // Comparator synchroniser.
   logic frame_evt; // One-cycle pulse per finished frame.

   // Stage one feeds only stage two in each chain.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         tgl_sync_q <= 3'h0;
         win_sync_q <= 2'h0;
         pk_sync_q <= 2'h0;
         cmp_sync_q <= 2'h0;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], frame_done_q};
         win_sync_q <= {win_sync_q[0], diversity_window_input};
         pk_sync_q <= {pk_sync_q[0], peak_window_input};
         cmp_sync_q <= {cmp_sync_q[0], compare_result};
      end
   end

   // The frame word stays stable while the done flag is high.
   assign frame_evt = tgl_sync_q[1] & ~tgl_sync_q[2];

   // ----------------------------------------------------------------
   // Input buffers and active registers
   // ----------------------------------------------------------------
   logic [7:0] buf_q [4]; // Input buffers indexed by address.
   rcsp_pkg::rcsp_active_t act_q; // Active settings.
   rcsp_pkg::rcsp_frame_t fr; // Frame as seen by the system domain.

   assign fr = frame_q;

   // Only the addressed buffer changes; reserved codes write nothing.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) begin
            buf_q[i] <= `RCSP_BYTE_RST;
         end
      end else if (frame_evt) begin
         if (fr.cmd.addr[2] == 1'b0) begin
            buf_q[fr.cmd.addr[1:0]] <= fr.data;
         end
      end
   end

   // Load copies every buffer at once, including this frame's byte.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         act_q <= '0;
      end else if (frame_evt && fr.cmd.load_strobe_bit) begin
         act_q.crystal_tune_converter <=
            (fr.cmd.addr == `RCSP_ADR_XTAL) ? fr.data[5:0]
                                            : buf_q[0][5:0];
         act_q.power_sense_converter <=
            (fr.cmd.addr == `RCSP_ADR_PSNS) ? fr.data[6:0]
                                            : buf_q[1][6:0];
         act_q.forward_sense <=
            (fr.cmd.addr == `RCSP_ADR_PSNS) ? fr.data[7] : buf_q[1][7];
         act_q.gain_converter <=
            (fr.cmd.addr == `RCSP_ADR_GAIN) ? fr.data[6:0]
                                            : buf_q[2][6:0];
         act_q.direct_adc_select <=
            (fr.cmd.addr == `RCSP_ADR_GAIN) ? fr.data[7] : buf_q[2][7];
         act_q.gate_bias_converter <=
            (fr.cmd.addr == `RCSP_ADR_BIAS) ? fr.data[5:0]
                                            : buf_q[3][5:0];
         act_q.power_class <=
            (fr.cmd.addr == `RCSP_ADR_BIAS) ? fr.data[7:6]
                                            : buf_q[3][7:6];
         act_q.bias_shutdown_output <= fr.cmd.bias_shutdown_bit;
         act_q.mode <= rcsp_pkg::rcsp_mode_t'(
            {fr.cmd.receive_enable_bit, fr.cmd.transmit_enable_bit});
      end
      // Without load nothing active moves.
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   // Every output is re-timed so each comes straight from a flip-flop.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         crystal_tune_converter <= 6'h00;
         power_sense_converter <= 7'h00;
         gain_converter <= 7'h00;
         gate_bias_converter <= 6'h00;
         gate_bias_enable <= 1'b0;
         power_class <= 2'h0;
         forward_sense <= 1'b0;
         direct_adc_select <= 1'b0;
         power_mode <= `RCSP_MODE_RST;
         bias_shutdown_output <= 1'b0;
         converter_enable <= 4'h0;
      end else begin
         crystal_tune_converter <= act_q.crystal_tune_converter;
         power_sense_converter <= act_q.power_sense_converter;
         gain_converter <= act_q.gain_converter;
         gate_bias_converter <= act_q.gate_bias_converter;
         power_class <= act_q.power_class;
         forward_sense <= act_q.forward_sense;
         direct_adc_select <= act_q.direct_adc_select;
         power_mode <= act_q.mode;
         bias_shutdown_output <= act_q.bias_shutdown_output;
         case (act_q.mode)
            rcsp_pkg::RCSP_TOTAL_SHUTDOWN: converter_enable <= 4'h0;
            rcsp_pkg::RCSP_TRANSMIT: converter_enable <= 4'hf;
            rcsp_pkg::RCSP_RECEIVE: converter_enable <= 4'h5;
            default: converter_enable <= 4'h9;
         endcase
         // Bias converter is off whenever shutdown bit is zero.
         gate_bias_enable <= act_q.bias_shutdown_output &&
                             act_q.mode != rcsp_pkg::RCSP_TOTAL_SHUTDOWN &&
                             act_q.mode != rcsp_pkg::RCSP_RECEIVE;
      end
   end

   // Gain stage runs only in transmit within the window; else all grounded.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sense_pulldown <= 3'h7;
      end else if (act_q.mode == rcsp_pkg::RCSP_TRANSMIT && pk_sync_q[1]) begin
         sense_pulldown <= act_q.forward_sense ? 3'h4 : 3'h3;
      end else begin
         sense_pulldown <= 3'h7;
      end
   end

   // ----------------------------------------------------------------
   // Diversity sequencer
   // ----------------------------------------------------------------
   rcsp_diversity u_div (
      .clock(clock),
      .rstn(rstn),
      .window_sync(win_sync_q[1]),
      .compare_in(cmp_sync_q[1]),
      .diversity_measure_control(diversity_measure_control),
      .best_antenna_output(best_antenna_output)
   );

endmodule

// ---- tb/rcsp_props.sv ----
// Checker for the output timing of the radio control serial port.
`timescale 1ns/10ps
// ----------------------------------------
// Checker
// ----------------------------------------
module rcsp_props (
   input wire logic clock, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic serial_clock, // Host serial clock.
   input wire logic frame_select_n, // Frame select, active low.
   input wire logic serial_data_out, // Serial data to the host.
   input wire logic diversity_window_input, // Diversity window pin.
   input wire logic diversity_measure_control, // Measure control.
   input wire logic best_antenna_output, // Best antenna result.
   input wire logic bias_shutdown_output, // Bias shutdown output.
   input wire logic [5:0] crystal_tune_converter, // Crystal code.
   input wire logic gate_bias_enable, // Gate bias enable.
   input wire logic [1:0] power_mode, // Receive, transmit enables.
   input wire logic [3:0] converter_enable, // Converter enables.
   input wire logic [2:0] sense_pulldown // Sense input pull-downs.
);
   // All checks live in the system clock domain.
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   a_reset_clear: assert property (
      $rose(rstn) |-> crystal_tune_converter == 6'h00 &&
      power_mode == 2'h0 && !best_antenna_output)
      else $error("outputs not cleared by reset");
   // The guard allows the enable to trail the shutdown output.
   a_bias_gates_off: assert property (
      !bias_shutdown_output && $stable(bias_shutdown_output)
      |-> !gate_bias_enable)
      else $error("gate bias enabled while shut down");
   a_mode_enables: assert property (
      $stable(power_mode) |-> converter_enable ==
      (power_mode == 2'h1 ? 4'hf : power_mode == 2'h2 ? 4'h5 :
      power_mode == 2'h3 ? 4'h9 : 4'h0))
      else $error("converter enables disagree with mode");
   a_pull_idle: assert property (
      power_mode != 2'h1 && $stable(power_mode)
      |-> sense_pulldown == 3'h7)
      else $error("sense input left floating");
   // Two sync stages plus the four clock settle time.
   a_div_wait: assert property (
      $rose(diversity_window_input) |->
      !diversity_measure_control [*5] ##[1:4] diversity_measure_control)
      else $error("measure control rose at the wrong time");
   a_div_acq: assert property (
      $rose(diversity_measure_control) |-> diversity_measure_control [*8])
      else $error("measure phase shorter than eight clocks");
   a_div_gap: assert property (
      $fell(diversity_measure_control) && diversity_window_input |->
      !diversity_measure_control [*4] ##1 diversity_measure_control)
      else $error("hold gap not four clocks");
   a_div_end: assert property (
      $fell(diversity_window_input) |-> ##1 diversity_measure_control
      ##[1:5] !diversity_measure_control)
      else $error("measure control did not drop after window");
   a_best_on_fall: assert property (
      $changed(best_antenna_output) |-> !diversity_window_input)
      else $error("best antenna changed inside window");
   a_dout_on_rise: assert property (
      $changed(serial_data_out) |-> $rose(serial_clock) || frame_select_n)
      else $error("serial output moved off the rising edge");

   c_best_high: cover property ($rose(best_antenna_output));
   c_standby: cover property (power_mode == 2'h3);
   c_div_done: cover property ($fell(diversity_measure_control));
endmodule

bind rcsp_top rcsp_props chk (.clock, .rstn, .serial_clock,
   .frame_select_n, .serial_data_out, .diversity_window_input,
   .diversity_measure_control, .best_antenna_output,
   .bias_shutdown_output, .crystal_tune_converter, .gate_bias_enable,
   .power_mode, .converter_enable, .sense_pulldown);

// ---- tb/rcsp_host.sv ----
// Host model that drives frames on the serial control port.
`timescale 1ns/10ps
// ----------------------------------------
// Host model
// ----------------------------------------
module rcsp_host (
   output logic serial_clock, // Serial clock, still between frames.
   output logic frame_select_n, // Frame select, active low.
   output logic serial_data_in, // Serial data to the block.
   input wire logic serial_data_out // Serial data from the block.
);
   // Idle with select high and clock and data low.
   initial begin
      serial_clock = 1'b0;
      frame_select_n = 1'b1;
      serial_data_in = 1'b0;
   end

   // Send the top n bits of w, MSB first, and collect the read byte.
   // A short n abandons the frame by raising select early.
   task automatic xfer(input logic [15:0] w, input int n,
      output logic [7:0] rd);
      int i;
      rd = 8'h00;
      #7.3 frame_select_n = 1'b0;
      #200;
      for (i = 15; i > 15 - n; i--) begin
         // Data moves well clear of the falling edge that samples it.
         #10 serial_data_in = w[i];
         #52.5 serial_clock = 1'b1;
         #62.5;
         if (i < 8) rd[i] = serial_data_out;
         serial_clock = 1'b0;
      end
      #100 serial_data_in = 1'b0;
      frame_select_n = 1'b1;
      #400;
   endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the radio control serial port.
`timescale 1ns/10ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
   logic clock, rstn, serial_clock, frame_select_n, serial_data_in;
   logic serial_data_out, diversity_window_input, peak_window_input;
   logic compare_result, diversity_measure_control, best_antenna_output;
   logic bias_shutdown_output, gate_bias_enable, forward_sense;
   logic direct_adc_select;
   logic [7:0] adc_result, rd;
   logic [5:0] crystal_tune_converter, gate_bias_converter;
   logic [6:0] power_sense_converter, gain_converter;
   logic [1:0] power_class, power_mode;
   logic [3:0] converter_enable;
   logic [2:0] sense_pulldown;
   logic [7:0] dv [4] = '{8'hea, 8'hd5, 8'h9b, 8'hb3}; // Buffer data.
   logic [3:0] ce [4] = '{4'h0, 4'hf, 4'h5, 4'h9}; // Enables by mode.
   int bad_count, checks_done, a;

   rcsp_top dut (.clock, .rstn, .serial_clock, .frame_select_n,
      .serial_data_in, .serial_data_out, .adc_result,
      .diversity_window_input, .peak_window_input, .compare_result,
      .diversity_measure_control, .best_antenna_output,
      .bias_shutdown_output, .crystal_tune_converter,
      .power_sense_converter, .gain_converter, .gate_bias_converter,
      .gate_bias_enable, .power_class, .forward_sense, .direct_adc_select,
      .power_mode, .converter_enable, .sense_pulldown);
   rcsp_host host (.serial_clock, .frame_select_n, .serial_data_in,
      .serial_data_out);

   // Build a frame word: start bit, command fields, data byte.
   function automatic logic [15:0] word(input logic [2:0] ad,
      input logic [1:0] md, input logic sd, ld, input logic [7:0] d);
      return {1'b1, ad, md, sd, ld, d};
   endfunction

   // Frames start from a falling system edge so no edges coincide.
   task automatic frame(input logic [15:0] w, input int n);
      @(negedge clock);
      host.xfer(w, n, rd);
   endtask

   task automatic chk(input logic [31:0] seen, exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // A hang is cut short long after the sequence should have ended.
   initial begin
      #300000;
      bad_count++;
      close_out();
   end

   initial begin
      bad_count = 0;
      checks_done = 0;
      rstn = 1'b0;
      adc_result = 8'h00;
      diversity_window_input = 1'b0;
      peak_window_input = 1'b0;
      compare_result = 1'b0;
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      chk({bias_shutdown_output, power_mode, best_antenna_output,
         converter_enable}, 'h0, "reset state");
      chk({crystal_tune_converter, power_sense_converter, gain_converter,
         gate_bias_converter}, 'h0, "reset codes");
      chk(sense_pulldown, 3'h7, "reset pulls");
      // Buffers fill without load; outputs must not move.
      for (a = 0; a < 4; a++) begin
         frame(word(a[2:0], 2'h1, 1'b1, 1'b0, dv[a]), 16);
         chk({crystal_tune_converter, gain_converter, power_mode}, 'h0,
            "no load");
      end
      // A load from a reserved address moves every buffer at once.
      frame(word(3'h5, 2'h1, 1'b1, 1'b1, 8'hff), 16);
      chk({crystal_tune_converter, power_sense_converter, gain_converter,
         gate_bias_converter}, {6'h2a, 7'h55, 7'h1b, 6'h33},
         "codes");
      chk({forward_sense, direct_adc_select, power_class}, 4'he,
         "selects");
      chk({power_mode, bias_shutdown_output, gate_bias_enable,
         converter_enable}, 8'h7f, "transmit");
      @(negedge clock) peak_window_input = 1'b1;
      repeat (8) @(negedge clock);
      chk(sense_pulldown, 3'h4, "forward pulls");
      peak_window_input = 1'b0;
      // An abandoned frame must change nothing.
      frame(word(3'h0, 2'h2, 1'b0, 1'b1, 8'h00), 12);
      chk({crystal_tune_converter, power_mode}, 8'ha9, "abort");
      for (a = 0; a < 4; a++) begin
         frame(word(3'h4, a[1:0], a != 3, 1'b1, 8'h00), 16);
         chk({power_mode, bias_shutdown_output, gate_bias_enable,
            converter_enable}, {a[1:0], a != 3, a == 1, ce[a]},
            "modes");
      end
      chk(crystal_tune_converter, 6'h2a, "abort buffer");
      @(negedge clock);
      adc_result = 8'ha6;
      frame(word(3'h7, 2'h1, 1'b1, 1'b0, 8'h00), 16);
      chk({rd, power_mode}, {8'ha6, 2'h3}, "read");
      frame(word(3'h0, 2'h1, 1'b1, 1'b0, 8'h11), 16);
      @(negedge clock);
      adc_result = 8'h5c;
      frame(word(3'h7, 2'h1, 1'b1, 1'b1, 8'h00), 16);
      chk({rd, 2'h0, crystal_tune_converter, power_mode},
         {8'h5c, 8'h11, 2'h1}, "read load");
      // Second antenna stronger, then first antenna stronger.
      for (a = 1; a >= 0; a--) begin
         @(negedge clock);
         compare_result = a[0];
         diversity_window_input = 1'b1;
         repeat (40) @(negedge clock);
         diversity_window_input = 1'b0;
         repeat (12) @(negedge clock);
         chk({best_antenna_output, diversity_measure_control},
            {a[0], 1'b0}, "diversity");
      end
      close_out();
   end
endmodule
